//--- pkg/msad_pkg.sv
// Purpose: constants and types for the memory address space decoder
// Assumes: 24-bit program space, 16-bit byte data space
// Notes: one number, one name
package msad_pkg;
   localparam int PA_W = 24;
   localparam int PC_W = 23;
   localparam int EA_W = 16;
   localparam int DW_W = 16;
   localparam logic [22:0] PC_RESET = 23'h000000;
   localparam logic [22:0] PC_STEP = 23'h000002;
   localparam logic [23:0] USER_TOP = 24'h7fffff;
   localparam logic [23:0] VEC_TOP = 24'h000200;
   localparam logic [23:0] VEC_GOTO = 24'h000000;
   localparam logic [23:0] VEC_START = 24'h000002;
   localparam logic [23:0] IVT_PRI_LO = 24'h000004;
   localparam logic [23:0] IVT_PRI_HI = 24'h0000ff;
   localparam logic [23:0] IVT_ALT_LO = 24'h000100;
   localparam logic [23:0] IVT_ALT_HI = 24'h0001ff;
   // last implemented user flash word; plain default
   localparam logic [23:0] FLASH_TOP = 24'h0157fe;
   localparam logic [23:0] CFG_LO = 24'hf80000;
   localparam logic [23:0] CFG_HI = 24'hf8ffff;
   localparam logic [23:0] IDENT_LO = 24'hff0000;
   localparam logic [23:0] IDENT_HI = 24'hffffff;
   localparam int TPAGE_HI_BIT = 7;
   localparam logic [7:0] TPAGE_RESET = 8'h00;
   localparam int EA_PSV_BIT = 15;
   // 30 kbytes of implemented data memory
   localparam logic [15:0] DATA_TOP = 16'h77ff;
   localparam logic [15:0] DW_RESET = 16'h0000;
   localparam logic [23:0] PW_RESET = 24'h000000;

   typedef enum logic [4:0] {
      PR_USER = 5'h01,
      PR_VECT = 5'h02,
      PR_CFG = 5'h04,
      PR_IDENT = 5'h08,
      PR_UNIMP = 5'h10
   } msad_region_type;
endpackage

//--- verilog/msad_decoder.sv
// Purpose: program and data address space decoding for a 16-bit core
// Assumes: memories answer combinationally in the cycle of the request
// Notes: read data and error flags are registered, one cycle late
`timescale 1ns/1ps
module msad_decoder (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // program counter control
   input wire logic pc_load,
   input wire logic [22:0] pc_load_addr,
   input wire logic pc_step_up,
   input wire logic pc_step_down,
   // table operations
   input wire logic tpage_wr,
   input wire logic [7:0] tpage_wdata,
   input wire logic table_read_op,
   input wire logic table_write_op,
   input wire logic [15:0] table_offset,
   input wire logic [15:0] table_wdata,
   // program memory
   output logic [23:0] prog_addr,
   input wire logic [23:0] prog_rdata,
   output logic prog_wr_en,
   output logic [2:0] prog_wr_be,
   output logic [23:0] prog_wr_data,
   // program status
   output logic [22:0] program_counter,
   output logic [7:0] table_page_select,
   output logic [23:0] fetch_word,
   output logic [15:0] table_rdata,
   output logic fetch_in_vectors,
   output logic fetch_ivt_pri,
   output logic fetch_ivt_alt,
   output logic fetch_fault,
   output logic table_fault,
   // data read path
   input wire logic rd_req,
   input wire logic rd_byte,
   input wire logic [15:0] rd_ea,
   // data write path
   input wire logic wr_req,
   input wire logic wr_byte,
   input wire logic [15:0] wr_ea,
   input wire logic [15:0] wr_wdata,
   // data memory
   output logic [14:0] ram_rd_addr,
   output logic ram_rd_en,
   input wire logic [15:0] ram_rdata,
   output logic [14:0] ram_wr_addr,
   output logic [1:0] ram_wr_be,
   output logic [15:0] ram_wr_data,
   // program visibility window
   output logic psv_rd_req,
   output logic [14:0] psv_offset,
   input wire logic [15:0] psv_rdata,
   // data results
   output logic [15:0] rd_data,
   output logic addr_error
);

   ////////////////////////////////////////////////////////////////////
   // decoding helpers

   function automatic msad_pkg::msad_region_type prog_region(
      input logic [23:0] a);
      if (a > msad_pkg::USER_TOP) begin
         if (a >= msad_pkg::IDENT_LO && a <= msad_pkg::IDENT_HI) begin
            prog_region = msad_pkg::PR_IDENT;
         end else if (a >= msad_pkg::CFG_LO && a <= msad_pkg::CFG_HI) begin
            prog_region = msad_pkg::PR_CFG;
         end else begin
            prog_region = msad_pkg::PR_UNIMP;
         end
      end else if (a < msad_pkg::VEC_TOP) begin
         prog_region = msad_pkg::PR_VECT;
      end else if (a <= msad_pkg::FLASH_TOP) begin
         prog_region = msad_pkg::PR_USER;
      end else begin
         prog_region = msad_pkg::PR_UNIMP;
      end
   endfunction

   // 2'b01 ram, 2'b10 visibility window, 2'b00 unimplemented
   function automatic logic [1:0] data_route(input logic [15:0] ea);
      if (ea[msad_pkg::EA_PSV_BIT]) begin
         data_route = 2'h2;
      end else if (ea <= msad_pkg::DATA_TOP) begin
         data_route = 2'h1;
      end else begin
         data_route = 2'h0;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // program counter and table page

   logic [22:0] pc_ff, nxt_pc;
   logic [7:0] tpage_ff, nxt_tpage;

   always_comb begin
      nxt_pc = pc_ff;
      nxt_tpage = tpage_ff;
      if (pc_load) begin
         nxt_pc = {pc_load_addr[22:1], 1'b0};
      end else if (pc_step_up) begin
         nxt_pc = pc_ff + msad_pkg::PC_STEP;
      end else if (pc_step_down) begin
         nxt_pc = pc_ff - msad_pkg::PC_STEP;
      end
      if (tpage_wr) begin
         nxt_tpage = tpage_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pc_ff <= msad_pkg::PC_RESET;
         tpage_ff <= msad_pkg::TPAGE_RESET;
      end else begin
         pc_ff <= nxt_pc;
         tpage_ff <= nxt_tpage;
      end
   end

   assign program_counter = pc_ff;
   assign table_page_select = tpage_ff;

   ////////////////////////////////////////////////////////////////////
   // program address selection and region checks

   logic table_op;
   logic [23:0] fetch_addr, tbl_addr;
   msad_pkg::msad_region_type fetch_reg, tbl_reg;
   logic tbl_ok, tbl_impl;

   assign table_op = table_read_op | table_write_op;
   // counter covers the lower half only, bit 23 is never set by a fetch
   assign fetch_addr = {1'b0, pc_ff};
   assign tbl_addr = {tpage_ff, table_offset};
   assign fetch_reg = prog_region(fetch_addr);
   assign tbl_reg = prog_region(tbl_addr);
   // upper half is reachable by table ops only through page bit 7
   assign tbl_ok = !tbl_addr[23] || tpage_ff[msad_pkg::TPAGE_HI_BIT];
   assign tbl_impl = tbl_ok && (tbl_reg != msad_pkg::PR_UNIMP);
   // both table halves address the same 24-bit location
   assign prog_addr = table_op ? {tbl_addr[23:1], 1'b0} : fetch_addr;

   ////////////////////////////////////////////////////////////////////
   // table write lanes

   always_comb begin
      prog_wr_en = table_write_op && tbl_impl;
      prog_wr_be = 3'h0;
      prog_wr_data = {8'h00, table_wdata};
      if (table_offset[0]) begin
         // upper word: only the top byte (bits 23:16) exists
         prog_wr_be = 3'h4;
         prog_wr_data = {table_wdata[7:0], 16'h0000};
      end else begin
         prog_wr_be = 3'h3;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // program read results

   logic [23:0] fw_ff, nxt_fw;
   logic [15:0] trd_ff, nxt_trd;
   logic vec_ff, nxt_vec, ivp_ff, nxt_ivp, iva_ff, nxt_iva;
   logic ffl_ff, nxt_ffl, tfl_ff, nxt_tfl;

   always_comb begin
      // table read wins the memory port; fetch result holds meanwhile
      nxt_fw = fw_ff;
      nxt_trd = trd_ff;
      if (!table_op) begin
         nxt_fw = (fetch_reg == msad_pkg::PR_UNIMP) ? msad_pkg::PW_RESET
                  : prog_rdata;
      end
      if (table_read_op) begin
         if (!tbl_impl) begin
            nxt_trd = msad_pkg::DW_RESET;
         end else if (table_offset[0]) begin
            nxt_trd = {8'h00, prog_rdata[23:16]};
         end else begin
            nxt_trd = prog_rdata[15:0];
         end
      end
      nxt_vec = fetch_reg == msad_pkg::PR_VECT;
      nxt_ivp = fetch_addr >= msad_pkg::IVT_PRI_LO
                && fetch_addr <= msad_pkg::IVT_PRI_HI;
      nxt_iva = fetch_addr >= msad_pkg::IVT_ALT_LO
                && fetch_addr <= msad_pkg::IVT_ALT_HI;
      nxt_ffl = fetch_reg == msad_pkg::PR_UNIMP;
      nxt_tfl = table_op && !tbl_ok;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         fw_ff <= msad_pkg::PW_RESET;
         trd_ff <= msad_pkg::DW_RESET;
         vec_ff <= 1'b0;
         ivp_ff <= 1'b0;
         iva_ff <= 1'b0;
         ffl_ff <= 1'b0;
         tfl_ff <= 1'b0;
      end else begin
         fw_ff <= nxt_fw;
         trd_ff <= nxt_trd;
         vec_ff <= nxt_vec;
         ivp_ff <= nxt_ivp;
         iva_ff <= nxt_iva;
         ffl_ff <= nxt_ffl;
         tfl_ff <= nxt_tfl;
      end
   end

   assign fetch_word = fw_ff;
   assign table_rdata = trd_ff;
   assign fetch_in_vectors = vec_ff;
   assign fetch_ivt_pri = ivp_ff;
   assign fetch_ivt_alt = iva_ff;
   assign fetch_fault = ffl_ff;
   assign table_fault = tfl_ff;

   ////////////////////////////////////////////////////////////////////
   // data read path

   logic [1:0] rd_rt, wr_rt;
   logic rd_mis, wr_mis;
   logic [15:0] rd_word;

   assign rd_rt = data_route(rd_ea);
   assign wr_rt = data_route(wr_ea);
   assign rd_mis = rd_req && !rd_byte && rd_ea[0];
   assign wr_mis = wr_req && !wr_byte && wr_ea[0];

   // word index drops the byte bit
   assign ram_rd_addr = rd_ea[15:1];
   assign ram_rd_en = rd_req && rd_rt == 2'h1;
   assign psv_rd_req = rd_req && rd_rt == 2'h2;
   assign psv_offset = rd_ea[14:0];

   always_comb begin
      case (rd_rt)
         2'h1: rd_word = ram_rdata;
         2'h2: rd_word = psv_rdata;
         default: rd_word = msad_pkg::DW_RESET;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // data write path

   logic wr_go;

   // misaligned store executes but never reaches memory
   assign wr_go = wr_req && wr_rt == 2'h1 && !wr_mis;
   assign ram_wr_addr = wr_ea[15:1];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_lane
         // lane 0 is the even byte, lane 1 the odd byte
         assign ram_wr_be[g] = wr_go
                               && (!wr_byte || wr_ea[0] == g[0]);
         assign ram_wr_data[8*g +: 8] = wr_byte ? wr_wdata[7:0]
                                        : wr_wdata[8*g +: 8];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // registered data results

   logic [15:0] rdd_ff, nxt_rdd;
   logic aer_ff, nxt_aer;

   always_comb begin
      nxt_rdd = rdd_ff;
      if (rd_req) begin
         if (rd_byte) begin
            nxt_rdd = {8'h00, rd_ea[0] ? rd_word[15:8]
                                       : rd_word[7:0]};
         end else begin
            // misaligned read still completes with the containing word
            nxt_rdd = rd_word;
         end
      end
      nxt_aer = rd_mis || wr_mis;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdd_ff <= msad_pkg::DW_RESET;
         aer_ff <= 1'b0;
      end else begin
         rdd_ff <= nxt_rdd;
         aer_ff <= nxt_aer;
      end
   end

   assign rd_data = rdd_ff;
   assign addr_error = aer_ff;

endmodule // msad_decoder

//--- tb/msad_mem_model.sv
// Purpose: program, data and visibility memories beside the decoder
// Assumes: each memory answers in the cycle of its address
// Notes: idle ports return inverted data
`timescale 1ns/1ps
module msad_mem_model (
   // program memory
   input wire logic [23:0] prog_addr,
   output logic [23:0] prog_rdata,
   // data memory
   input wire logic [14:0] ram_rd_addr,
   input wire logic ram_rd_en,
   output logic [15:0] ram_rdata,
   // visibility window
   input wire logic psv_rd_req,
   input wire logic [14:0] psv_offset,
   output logic [15:0] psv_rdata
);
   //////////////////////////////
   logic [15:0] rw, pw;
   assign rw = {ram_rd_addr, 1'b1} ^ 16'h9e37;
   assign pw = {psv_offset, 1'b0} ^ 16'h5b21;
   // holes still answer, so the decoder must blank them itself
   assign prog_rdata = {prog_addr[7:0] ^ 8'ha5, prog_addr[15:0] ^ 16'h3c3c};
   assign ram_rdata = ram_rd_en ? rw : ~rw;
   assign psv_rdata = psv_rd_req ? pw : ~pw;
endmodule // msad_mem_model

//--- tb/msad_chk.sv
// Purpose: port checks on the decoder
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every decoder instance
`timescale 1ns/1ps
module msad_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // program side
   input wire logic pc_load,
   input wire logic pc_step_up,
   input wire logic table_read_op,
   input wire logic table_write_op,
   input wire logic [22:0] program_counter,
   input wire logic [7:0] table_page_select,
   input wire logic fetch_in_vectors,
   input wire logic fetch_ivt_pri,
   // data side
   input wire logic rd_req,
   input wire logic rd_byte,
   input wire logic [15:0] rd_ea,
   input wire logic wr_req,
   input wire logic wr_byte,
   input wire logic [15:0] wr_ea,
   input wire logic ram_rd_en,
   input wire logic [1:0] ram_wr_be,
   input wire logic [15:0] ram_rdata,
   input wire logic psv_rd_req,
   input wire logic [15:0] rd_data,
   input wire logic addr_error
);
   //////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic fetch;
   assign fetch = !table_read_op && !table_write_op;
   sequence s_odd_wr;
      wr_req && !wr_byte && wr_ea[0];
   endsequence
   sequence s_byte_rd;
      rd_req && rd_byte && rd_ea <= 16'h77ff;
   endsequence
   a_reset_clears: assert property ($fell(rst) |-> program_counter == 23'h0
      && table_page_select == 8'h00 && rd_data == 16'h0000) else $error("bad reset state");
   a_pc_step: assert property (pc_step_up && !pc_load |=>
      program_counter == $past(program_counter) + 23'h2) else $error("bad step");
   a_vector_flags: assert property (fetch |=>
      fetch_in_vectors == ($past(program_counter) < 23'h200) && fetch_ivt_pri ==
      ($past(program_counter) >= 23'h4 && $past(program_counter) <= 23'hff))
      else $error("bad vector flags");
   a_psv_route: assert property (psv_rd_req == (rd_req && rd_ea[15]))
      else $error("bad window request");
   a_ram_enable: assert property (ram_rd_en == (rd_req && rd_ea <= 16'h77ff))
      else $error("bad ram enable");
   a_odd_write: assert property (s_odd_wr |-> ram_wr_be == 2'b00 ##1 addr_error)
      else $error("odd write not refused");
   a_byte_read: assert property (s_byte_rd |=> rd_data == {8'h00, $past(rd_ea[0]) ?
      $past(ram_rdata[15:8]) : $past(ram_rdata[7:0])}) else $error("bad byte read");
   a_hole_zero: assert property (rd_req && rd_ea[15:11] == 5'h0f |=> rd_data == 16'h0)
      else $error("hole not zero");
endmodule // msad_chk
bind msad_decoder msad_chk chk (.*);

//--- tb/memory_address_space_decoder_tb.sv
// Purpose: self-checking bench for the address space decoder
// Assumes: 25 MHz clock, inputs move 1 ns after the rising edge
// Notes: fixed seed; corner addresses lead the random reads
`timescale 1ns/1ps
module memory_address_space_decoder_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pc_load = 1'b0, pc_step_up = 1'b0, pc_step_down = 1'b0, tpage_wr = 1'b0;
   logic table_read_op = 1'b0, table_write_op = 1'b0, rd_req = 1'b0, rd_byte = 1'b0;
   logic wr_req = 1'b0, wr_byte = 1'b0;
   logic [22:0] pc_load_addr = '0, program_counter;
   logic [7:0] tpage_wdata = '0, table_page_select;
   logic [15:0] table_offset = '0, table_wdata = '0, rd_ea = '0, wr_ea = '0, wr_wdata = '0;
   logic [15:0] table_rdata, ram_rdata, ram_wr_data, psv_rdata, rd_data;
   logic [23:0] prog_addr, prog_rdata, prog_wr_data, fetch_word;
   logic [14:0] ram_rd_addr, ram_wr_addr, psv_offset;
   logic [2:0] prog_wr_be;
   logic [1:0] ram_wr_be;
   logic prog_wr_en, fetch_in_vectors, fetch_ivt_pri, fetch_ivt_alt, fetch_fault, table_fault;
   logic ram_rd_en, psv_rd_req, addr_error;
   logic [15:0] cor [6] = '{16'h77fe, 16'h7800, 16'h8001, 16'hffff, 16'h0003, 16'h7fff};
   logic [16:0] wc [5] = '{17'h10001, 17'h10100, 17'h00002, 17'h00003, 17'h17800};
   logic [1:0] wbe [5] = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h0};
   int n_errors = 0;
   int checks = 0;
   msad_decoder dut (.*);
   msad_mem_model mem (.*);
   //////////////////////////////
   function automatic logic [23:0] pp(input logic [23:0] a);
      return {a[7:0] ^ 8'ha5, a[15:0] ^ 16'h3c3c};
   endfunction
   // window and holes first: bit 15 outranks the size limit
   function automatic logic [15:0] rdx(input logic [15:0] ea, input logic b);
      logic [15:0] w;
      w = ea[15] ? {ea[14:0], 1'b0} ^ 16'h5b21 :
         ea > 16'h77ff ? 16'h0 : {ea[15:1], 1'b1} ^ 16'h9e37;
      return b ? {8'h00, ea[0] ? w[15:8] : w[7:0]} : w;
   endfunction
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [23:0] e, g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic close_out;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // c is load, up, down; e is the counter we expect afterwards
   task automatic go(input logic [2:0] c, input logic [22:0] a, e);
      logic h;
      h = e > 23'h0157fe;
      {pc_load, pc_step_up, pc_step_down, pc_load_addr} = {c, a};
      tick;
      {pc_load, pc_step_up, pc_step_down} = 3'h0;
      tick;
      chk("pc", {1'b0, e}, {1'b0, program_counter});
      chk("fetch", h ? 24'h0 : pp({1'b0, e}), fetch_word);
      chk("fault", {23'h0, h}, {23'h0, fetch_fault});
   endtask
   initial forever #20 clk = ~clk;
   initial begin
      repeat (3000) tick;
      n_errors++;
      close_out;
   end
   initial begin
      logic [15:0] ea;
      logic [23:0] w;
      logic b;
      void'($urandom(32'h6339fb07));
      repeat (5) tick;
      rst = 1'b0;
      tick;
      chk("boot", pp(24'h0), fetch_word);
      chk("vec", 24'h1, {23'h0, fetch_in_vectors});
      go(3'b010, '0, 23'h2);
      go(3'b011, '0, 23'h4);
      go(3'b001, '0, 23'h2);
      go(3'b110, 23'h0157fe, 23'h0157fe);
      go(3'b100, 23'h000011, 23'h10);
      chk("pri", 24'h1, {23'h0, fetch_ivt_pri});
      go(3'b100, 23'h000100, 23'h100);
      chk("alt", 24'h1, {23'h0, fetch_ivt_alt});
      go(3'b100, 23'h015800, 23'h015800);
      go(3'b100, 23'h7ffffe, 23'h7ffffe);
      // page f8 puts the table window on the configuration area
      {tpage_wr, tpage_wdata} = {1'b1, 8'hf8};
      tick;
      {tpage_wr, table_read_op, table_offset} = {1'b0, 1'b1, 16'h0001};
      chk("page", 24'h0000f8, {16'h0, table_page_select});
      w = pp(24'hf80000);
      #5 chk("taddr", 24'hf80000, prog_addr);
      tick;
      table_offset = 16'h0000;
      chk("tup", {16'h0, w[23:16]}, {8'h00, table_rdata});
      tick;
      chk("tlo", {8'h00, w[15:0]}, {8'h00, table_rdata});
      {table_read_op, table_write_op, table_offset, table_wdata} = {2'b01, 32'h000312c4};
      #5 chk("twr", 24'h000cc4, {12'h0, prog_wr_en, prog_wr_be, prog_wr_data[23:16]});
      tick;
      {tpage_wr, tpage_wdata, table_offset} = {1'b1, 8'h80, 16'h0000};
      #5 chk("twl", 24'h0b12c4, {4'h0, prog_wr_en, prog_wr_be, prog_wr_data[15:0]});
      tick;
      // page 80 points into an unimplemented hole of the upper half
      {tpage_wr, table_read_op} = 2'b01;
      #5 chk("twno", 24'h0, {23'h0, prog_wr_en});
      tick;
      chk("tunimp", 24'h0, {8'h00, table_rdata});
      chk("tflt", 24'h0, {23'h0, table_fault});
      {tpage_wr, tpage_wdata, table_read_op, table_write_op} = {1'b1, 8'h00, 2'b00};
      tick;
      {tpage_wr, table_read_op, table_offset} = {1'b0, 1'b1, 16'h0002};
      tick;
      chk("tlow", pp(24'h000002) & 24'h00ffff, {8'h00, table_rdata});
      chk("tflt0", 24'h0, {23'h0, table_fault});
      table_read_op = 1'b0;
      for (int i = 0; i < 40; i++) begin
         ea = i < 6 ? cor[i] : 16'($urandom);
         b = i < 6 ? i[0] : 1'($urandom);
         {rd_req, rd_byte, rd_ea} = {1'b1, b, ea};
         tick;
         chk("rd", {8'h00, rdx(ea, b)}, {8'h00, rd_data});
         chk("rd_err", {23'h0, !b && ea[0]}, {23'h0, addr_error});
      end
      {rd_byte, rd_ea} = {1'b0, 16'h0010};
      for (int i = 0; i < 5; i++) begin
         {wr_req, wr_byte, wr_ea, wr_wdata} = {1'b1, wc[i], 16'ha55a};
         #5 chk("be", {22'h0, wbe[i]}, {22'h0, ram_wr_be});
         chk("waddr", {9'h0, wc[i][15:1]}, {9'h0, ram_wr_addr});
         chk("wdata", {8'h00, wc[i][16] ? 16'h5a5a : 16'ha55a}, {8'h00, ram_wr_data});
         tick;
         chk("wr_err", {23'h0, i == 3}, {23'h0, addr_error});
         chk("rd_ind", {8'h00, rdx(16'h0010, 1'b0)}, {8'h00, rd_data});
      end
      {wr_req, rd_req} = 2'b00;
      close_out;
   end
endmodule // memory_address_space_decoder_tb
